/* File: common/sgs_defines.svh */
// Offsets, field positions, reset values and timing counts of the setting group selector
`ifndef SGS_DEFINES_SVH
`define SGS_DEFINES_SVH

// Register byte offsets
`define SGS_REG_CFG 8'h00
`define SGS_REG_TIMEOUT 8'h04
`define SGS_REG_STATE 8'h08
`define SGS_REG_IRQ_STAT 8'h0c
`define SGS_REG_IRQ_MASK 8'h10

// Configuration fields
`define SGS_CFG_RANGE_LSB 0
`define SGS_CFG_RANGE_MSB 2
`define SGS_CFG_STEP_ACK 3
`define SGS_CFG_BIT_ACK 4

// State register fields
`define SGS_ST_POS_LSB 0
`define SGS_ST_PRE_LSB 4
`define SGS_ST_GRP_LSB 8
`define SGS_ST_FSM_LSB 16

// Interrupt status bit positions
`define SGS_IRQ_APPLIED 0
`define SGS_IRQ_RANGE 1
`define SGS_IRQ_STEP 2
`define SGS_IRQ_BIT 3
`define SGS_IRQ_PWR 4
`define SGS_IRQ_W 5

// Reset values
`define SGS_CFG_RST 5'h07
`define SGS_TIMEOUT_RST 16'h1388
`define SGS_MASK_RST 5'h00

// Timing: clock period, tick period and alarm length
`define SGS_CLK_PERIOD_NS 4
`define SGS_TICK_NS 1000000
`define SGS_TICK_CYCLES ((`SGS_TICK_NS) / (`SGS_CLK_PERIOD_NS))
`define SGS_ALARM_MS 3000
`define SGS_ALARM_TICKS 16'd3000

`endif

/* File: common/sgs_pkg.sv */
// Types shared by the setting group selector modules
package sgs_pkg;

   // Selector sequencer states, one-hot
   typedef enum logic [3:0] {
      SGS_INIT = 4'b0001,
      SGS_IDLE = 4'b0010,
      SGS_STEP = 4'b0100,
      SGS_BIT = 4'b1000
   } sgs_state_e;

   // Alarm outputs travel together
   typedef struct packed {
      logic range;
      logic step;
      logic bits;
      logic pwr;
   } sgs_alarm_s;

   // Non-volatile position store write port
   typedef struct packed {
      logic stb;
      logic [2:0] pos;
   } sgs_nv_s;

endpackage : sgs_pkg

/* File: rtl/sgs_timer.sv */
// Tick-driven one-shot timer used for time-outs and alarm lengths
`timescale 1ns/1ps
module sgs_timer #(
   parameter int W = 16
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic tick,
   input wire logic load,
   input wire logic stop,
   input wire logic [W-1:0] count,
   // Status
   output logic busy,
   output logic done
);
   logic [W-1:0] cnt_reg; // Remaining ticks
   logic busy_reg; // Timer running
   logic done_reg; // Expiry pulse
   wire last = busy_reg && tick && (cnt_reg <= {{(W-1){1'b0}}, 1'b1}); // Final tick

   // Load wins over stop and over expiry, so a restart never gets lost
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (ce) begin
         done_reg <= 1'b0;
         if (load) begin
            cnt_reg <= count;
            busy_reg <= 1'b1;
         end else if (stop) begin
            busy_reg <= 1'b0;
         end else if (last) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end else if (busy_reg && tick) begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;
endmodule : sgs_timer

/* File: rtl/sgs_top.sv */
// Setting group arbiter and selector switch with alarms and register port
`timescale 1ns/1ps
`include "sgs_defines.svh"
module sgs_top #(
   parameter int NUM_GROUPS = 6,
   parameter int TICK_CYCLES = `SGS_TICK_CYCLES
) (
   // Clock, reset, enable
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Group control operands
   input wire logic GROUP_CHANGE_BLOCK,
   input wire logic [NUM_GROUPS-1:1] GROUP_REQ,
   output logic [NUM_GROUPS-1:0] GROUP_LED,
   // Selector control operands
   input wire logic STEP_UP,
   input wire logic STEP_ACK,
   input wire logic [2:0] BIT_WORD,
   input wire logic BIT_ACK,
   input wire logic POWERUP_SYNC,
   output logic [2:0] SEL_POS,
   output sgs_pkg::sgs_alarm_s ALARMS,
   // Non-volatile store
   output sgs_pkg::sgs_nv_s NV_WR,
   input wire logic [2:0] NV_RD_DATA,
   // Interrupt
   output logic IRQ
);
   import sgs_pkg::*;

   localparam int NIN = NUM_GROUPS + 6; // Synchronised input count

   // Wrap a step inside 1..range
   function automatic logic [2:0] step_next(input logic [2:0] p, input logic [2:0] range);
      step_next = (p >= range) ? 3'h1 : p + 3'h1;
   endfunction : step_next

   // Position valid: 1..range
   function automatic logic in_range(input logic [2:0] p, input logic [2:0] range);
      in_range = (p != 3'h0) && (p <= range);
   endfunction : in_range

   // Input synchroniser, three stages
   logic [NIN-1:0] s1_reg, s2_reg, s3_reg; // Raw stages
   logic [NIN-1:0] in_reg; // Accepted levels
   logic [NIN-1:0] in_prev_reg; // Previous accepted levels
   wire [NIN-1:0] raw_in = {GROUP_CHANGE_BLOCK, GROUP_REQ, BIT_ACK, BIT_WORD, STEP_ACK, STEP_UP};
   // Change counts only once stages two and three agree
   wire [NIN-1:0] in_next = (s2_reg & s3_reg) | (in_reg & (s2_reg | s3_reg));

   // Sync chain
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         in_reg <= '0;
         in_prev_reg <= '0;
      end else if (CE) begin
         s1_reg <= raw_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         in_reg <= in_next;
         in_prev_reg <= in_reg;
      end
   end

   // Decoded inputs and edges
   wire step_rise = in_reg[0] & ~in_prev_reg[0];
   wire sack_rise = in_reg[1] & ~in_prev_reg[1];
   wire [2:0] word = in_reg[4:2];
   wire word_chg = (in_reg[4:2] != in_prev_reg[4:2]);
   wire back_rise = in_reg[5] & ~in_prev_reg[5];
   wire [NUM_GROUPS-1:1] greq = in_reg[NUM_GROUPS+4:6];
   wire blk = in_reg[NIN-1];

   // Register file
   logic [4:0] cfg_reg; // Range and mode bits
   logic [15:0] timeout_reg; // Time-out in ticks (ms)
   logic [`SGS_IRQ_W-1:0] irq_stat_reg; // Sticky events
   logic [`SGS_IRQ_W-1:0] irq_mask_reg; // Event enables
   logic [31:0] rdata_reg; // Read data
   wire [2:0] range = cfg_reg[`SGS_CFG_RANGE_MSB:`SGS_CFG_RANGE_LSB];
   wire step_ack_mode = cfg_reg[`SGS_CFG_STEP_ACK];
   wire bit_ack_mode = cfg_reg[`SGS_CFG_BIT_ACK];
   wire wr_cfg = WR && (ADDR == `SGS_REG_CFG);
   wire wr_to = WR && (ADDR == `SGS_REG_TIMEOUT);
   wire wr_stat = WR && (ADDR == `SGS_REG_IRQ_STAT);
   wire wr_mask = WR && (ADDR == `SGS_REG_IRQ_MASK);

   // Tick divider for all timers
   logic [31:0] div_reg; // Cycle counter
   logic tick_reg; // One-cycle tick
   wire div_end = (div_reg >= 32'(TICK_CYCLES - 1));

   // Fixed tick from the system clock, cleared by reset
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else if (CE) begin
         div_reg <= div_end ? 32'h0 : div_reg + 32'h1;
         tick_reg <= div_end;
      end
   end

   // Group arbiter
   logic [NUM_GROUPS-1:0] grp_reg; // One-hot active group
   logic [NUM_GROUPS-1:0] grp_next;

   // Priority pick: highest request, else group 1
   always_comb begin
      grp_next = '0;
      grp_next[0] = 1'b1;
      for (int i = 1; i < NUM_GROUPS; i++) begin
         if (greq[i]) begin
            grp_next = '0;
            grp_next[i] = 1'b1;
         end
      end
   end

   // Active group, frozen while blocked
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         grp_reg <= {{(NUM_GROUPS-1){1'b0}}, 1'b1};
      end else if (CE && !blk) begin
         grp_reg <= grp_next;
      end
   end

   assign GROUP_LED = grp_reg;

   // Selector sequencer
   sgs_state_e state_reg, state_next;
   logic [2:0] pos_reg, pos_next; // Applied position
   logic [2:0] pre_reg, pre_next; // Pre-selected position
   logic [2:0] init_reg; // Settle count; one past the chain so the word has landed
   logic capture_reg; // Power-up strap copy
   logic apply, discard, load_to, range_err, pwr_err;

   // Timers: sequence time-out and four alarm lengths
   logic to_done, to_busy;
   logic a_range, a_step, a_bit, a_pwr;
   wire step_active = (state_reg == SGS_STEP);
   wire bit_active = (state_reg == SGS_BIT);
   wire step_fail = to_done && step_active && step_ack_mode;
   wire bit_fail = to_done && bit_active && bit_ack_mode;
   wire word_ok = in_range(word, range);
   wire [15:0] alarm_ticks = `SGS_ALARM_TICKS; // Every alarm stands its full length
   wire no_stop = 1'b0; // Alarms are never cut short

   // One time-out for both modes
   sgs_timer #(.W(16)) u_to (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .tick(tick_reg),
      .load(load_to), .stop(apply | discard), .count(timeout_reg),
      .busy(to_busy), .done(to_done)
   );
   sgs_timer #(.W(16)) u_arange (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .tick(tick_reg),
      .load(range_err), .stop(no_stop), .count(alarm_ticks),
      .busy(a_range), .done()
   );
   sgs_timer #(.W(16)) u_astep (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .tick(tick_reg),
      .load(step_fail), .stop(no_stop), .count(alarm_ticks),
      .busy(a_step), .done()
   );
   sgs_timer #(.W(16)) u_abit (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .tick(tick_reg),
      .load(bit_fail), .stop(no_stop), .count(alarm_ticks),
      .busy(a_bit), .done()
   );
   sgs_timer #(.W(16)) u_apwr (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .tick(tick_reg),
      .load(pwr_err), .stop(no_stop), .count(alarm_ticks),
      .busy(a_pwr), .done()
   );

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      pos_next = pos_reg;
      pre_next = pre_reg;
      apply = 1'b0;
      discard = 1'b0;
      load_to = 1'b0;
      range_err = 1'b0;
      pwr_err = 1'b0;
      unique case (state_reg)
         // Wait for synchronised word, then choose the start position
         SGS_INIT: begin
            if (init_reg == 3'h4) begin
               state_next = SGS_IDLE;
               if (capture_reg) begin
                  pos_next = word_ok ? word : 3'h0;
                  pwr_err = !word_ok;
               end else begin
                  pos_next = in_range(NV_RD_DATA, range) ? NV_RD_DATA : 3'h0;
                  pwr_err = !in_range(NV_RD_DATA, range);
               end
               pre_next = pos_next;
            end
         end
         // Either input may start a sequence; step is checked first
         SGS_IDLE: begin
            if (step_rise) begin
               pre_next = step_next(pos_reg, range);
               load_to = 1'b1;
               state_next = SGS_STEP;
            end else if (word_chg && word != 3'h0) begin
               if (word_ok) begin
                  pre_next = word;
                  load_to = 1'b1;
                  state_next = SGS_BIT;
               end else begin
                  range_err = 1'b1;
               end
            end
         end
         // Stepping: word input ignored until done
         SGS_STEP: begin
            if (step_rise) begin
               pre_next = step_next(pre_reg, range);
               load_to = 1'b1;
            end else if (step_ack_mode && sack_rise) begin
               apply = 1'b1;
            end else if (to_done) begin
               apply = !step_ack_mode;
               discard = step_ack_mode;
            end
         end
         // Word sequence: step input ignored until done
         SGS_BIT: begin
            if (word_chg && word != 3'h0) begin
               if (word_ok) begin
                  pre_next = word;
                  load_to = 1'b1;
               end else begin
                  range_err = 1'b1;
               end
            end else if (bit_ack_mode && back_rise) begin
               apply = 1'b1;
            end else if (to_done) begin
               apply = !bit_ack_mode;
               discard = bit_ack_mode;
            end
         end
      endcase
      if (apply) begin
         pos_next = pre_reg;
         state_next = SGS_IDLE;
      end
      if (discard) begin
         pre_next = pos_reg;
         state_next = SGS_IDLE;
      end
   end

   // Sequencer registers and store write
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg <= SGS_INIT;
         pos_reg <= 3'h0;
         pre_reg <= 3'h0;
         init_reg <= 3'h0;
         capture_reg <= 1'b0;
         NV_WR <= '0;
      end else if (CE) begin
         state_reg <= state_next;
         pos_reg <= pos_next;
         pre_reg <= pre_next;
         // Strap caught after release, not under reset
         if (state_reg == SGS_INIT) begin
            init_reg <= init_reg + 3'h1;
            capture_reg <= POWERUP_SYNC;
         end
         NV_WR.stb <= apply;
         NV_WR.pos <= apply ? pre_reg : NV_WR.pos;
      end
   end

   assign SEL_POS = pos_reg;
   assign ALARMS = '{range: a_range, step: a_step, bits: a_bit, pwr: a_pwr};

   // Interrupt events; set wins over a same-cycle clear
   wire [`SGS_IRQ_W-1:0] irq_ev = {pwr_err, bit_fail, step_fail, range_err, apply};

   // Register writes
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cfg_reg <= `SGS_CFG_RST;
         timeout_reg <= `SGS_TIMEOUT_RST;
         irq_stat_reg <= '0;
         irq_mask_reg <= `SGS_MASK_RST;
      end else if (CE) begin
         if (wr_cfg) begin
            cfg_reg <= WDATA[4:0];
         end
         if (wr_to) begin
            timeout_reg <= WDATA[15:0];
         end
         if (wr_mask) begin
            irq_mask_reg <= WDATA[`SGS_IRQ_W-1:0];
         end
         irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? WDATA[`SGS_IRQ_W-1:0] : '0)) | irq_ev;
      end
   end

   // Read mux; unmapped addresses read zero
   wire [31:0] st_word = {12'h0, state_reg, 2'h0, NUM_GROUPS'(grp_reg), 1'b0, pre_reg,
                          1'b0, pos_reg};
   wire [31:0] rd_mux = (ADDR == `SGS_REG_CFG) ? {27'h0, cfg_reg} :
                        (ADDR == `SGS_REG_TIMEOUT) ? {16'h0, timeout_reg} :
                        (ADDR == `SGS_REG_STATE) ? st_word :
                        (ADDR == `SGS_REG_IRQ_STAT) ? {27'h0, irq_stat_reg} :
                        (ADDR == `SGS_REG_IRQ_MASK) ? {27'h0, irq_mask_reg} : 32'h0;

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_reg <= 32'h0;
      end else if (CE) begin
         rdata_reg <= RD ? rd_mux : 32'h0;
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule : sgs_top

/* File: tb/sgs_top_checker.sv */
// Port-level checker for the setting group selector, bound to its top
`timescale 1ns/1ps
module sgs_top_checker #(
   parameter int NUM_GROUPS = 6,
   parameter int TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Register port
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // Group operands
   input wire logic GROUP_CHANGE_BLOCK,
   input wire logic [NUM_GROUPS-1:1] GROUP_REQ,
   input wire logic [NUM_GROUPS-1:0] GROUP_LED,
   // Selector outputs
   input wire logic [2:0] SEL_POS,
   input wire sgs_pkg::sgs_alarm_s ALARMS,
   input wire sgs_pkg::sgs_nv_s NV_WR
);
   import sgs_pkg::*;
   // Alarm length in clocks; one tick of slack since events land mid-tick
   localparam int ALARM_CYC = 3000 * TICK_CYCLES;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   int hi_grp; // Highest requested group number
   logic [31:0] rng_cnt_reg; // Clocks the range alarm has stood
   logic [3:0] up_cnt_reg; // Clocks since release, saturating

   // Priority pick, group 1 by default
   always_comb begin
      hi_grp = 0;
      for (int i = 1; i < NUM_GROUPS; i++) begin
         if (GROUP_REQ[i]) begin
            hi_grp = i;
         end
      end
   end

   // Helper counters
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rng_cnt_reg <= 32'h0;
         up_cnt_reg <= 4'h0;
      end else begin
         rng_cnt_reg <= ALARMS.range ? rng_cnt_reg + 32'h1 : 32'h0;
         up_cnt_reg <= (up_cnt_reg == 4'hf) ? up_cnt_reg : up_cnt_reg + 4'h1;
      end
   end

   led_onehot_a: assert property ($onehot(GROUP_LED))
      else $error("group indicator not one-hot");
   led_hold_a: assert property (GROUP_CHANGE_BLOCK [*8] |-> $stable(GROUP_LED))
      else $error("active group changed while blocked");
   led_prio_a: assert property ((!GROUP_CHANGE_BLOCK && $stable(GROUP_REQ)) [*8]
      |-> GROUP_LED == (NUM_GROUPS'(1) << hi_grp)) else $error("wrong active group");
   nv_pulse_a: assert property (NV_WR.stb |=> !NV_WR.stb)
      else $error("store strobe longer than one cycle");
   nv_pos_a: assert property (NV_WR.stb |-> NV_WR.pos == SEL_POS)
      else $error("stored position differs from applied");
   pos_change_a: assert property (up_cnt_reg == 4'hf && $changed(SEL_POS) |-> NV_WR.stb)
      else $error("position changed without being stored");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside its cycle");
   range_len_a: assert property ($fell(ALARMS.range) |-> rng_cnt_reg >= ALARM_CYC - TICK_CYCLES
      && rng_cnt_reg <= ALARM_CYC + TICK_CYCLES) else $error("range alarm length wrong");
   step_len_a: assert property ($rose(ALARMS.step) |-> $stable(SEL_POS) ##1 ALARMS.step [*8])
      else $error("step alarm applied or too short");

   // Main scenarios reached
   cover property (NV_WR.stb);
   cover property ($rose(ALARMS.range));
   cover property ($rose(ALARMS.step));
   cover property (GROUP_CHANGE_BLOCK [*8] ##1 $changed(GROUP_REQ));
endmodule : sgs_top_checker

bind sgs_top sgs_top_checker #(.NUM_GROUPS(NUM_GROUPS), .TICK_CYCLES(TICK_CYCLES)) chk_u (
   .CLK, .SYS_RST, .RD, .RDATA, .GROUP_CHANGE_BLOCK, .GROUP_REQ, .GROUP_LED, .SEL_POS,
   .ALARMS, .NV_WR);

/* File: tb/sgs_operands.sv */
// Model of the pushbuttons and logic operands feeding the selector
`timescale 1ns/1ps
module sgs_operands #(
   parameter int STEP_GAP = 200
) (
   // Clock
   input wire logic clk,
   // Selector operands
   output logic step_up,
   output logic step_ack,
   output logic [2:0] bit_word,
   output logic bit_ack,
   // Group operands
   output logic [5:1] group_req,
   output logic group_block
);
   int gap_cnt = 0; // Clocks since the last step pulse

   // Word 3 at power-up so a synchronising start has something to take
   initial begin
      step_up = 1'b0;
      step_ack = 1'b0;
      bit_ack = 1'b0;
      bit_word = 3'h3;
      group_req = 5'h00;
      group_block = 1'b0;
   end

   // Step spacing, saturating
   always @(posedge clk) begin
      gap_cnt <= step_up ? 0 : (gap_cnt < STEP_GAP ? gap_cnt + 1 : gap_cnt);
   end

   // One press: 0 step, 1 step ack, 2 word ack; held four clocks for the synchronisers
   task automatic pulse(input int sel);
      while (sel == 0 && gap_cnt < STEP_GAP) begin
         @(posedge clk);
      end
      @(posedge clk);
      step_up <= (sel == 0);
      step_ack <= (sel == 1);
      bit_ack <= (sel == 2);
      repeat (4) @(posedge clk);
      step_up <= 1'b0;
      step_ack <= 1'b0;
      bit_ack <= 1'b0;
   endtask : pulse

   // Word and group levels
   task automatic set_word(input logic [2:0] w);
      @(posedge clk);
      bit_word <= w;
   endtask : set_word

   task automatic set_groups(input logic [5:1] r, input logic b);
      @(posedge clk);
      group_req <= r;
      group_block <= b;
   endtask : set_groups
endmodule : sgs_operands

/* File: tb/tb_setting_group_selector.sv */
// Self-checking bench for the setting group selector
`timescale 1ns/1ps
module tb_setting_group_selector;
   import sgs_pkg::*;
   localparam int TICK = 4;
   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic CE = 1'b1; // Clock enable, dropped once to show a frozen write
   logic POWERUP_SYNC = 1'b1;
   logic [2:0] NV_RD_DATA = 3'h2;
   logic [31:0] RDATA;
   logic [5:0] GROUP_LED;
   logic [2:0] SEL_POS, BIT_WORD;
   logic IRQ, STEP_UP, STEP_ACK, BIT_ACK, GROUP_CHANGE_BLOCK;
   logic [5:1] GROUP_REQ, req;
   logic [5:0] grp;
   sgs_alarm_s ALARMS;
   sgs_nv_s NV_WR;
   logic [31:0] rd_q[$]; // Expected read answers
   logic [2:0] ap_q[$]; // Expected applied positions
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int i;
   logic rd_d = 1'b0;
   logic [31:0] rng = 32'd16600;

   always #2 CLK = ~CLK;

   sgs_top #(.NUM_GROUPS(6), .TICK_CYCLES(TICK)) dut_u (.CLK, .SYS_RST, .CE, .ADDR,
      .WDATA, .WR, .RD, .RDATA, .GROUP_CHANGE_BLOCK, .GROUP_REQ, .GROUP_LED, .STEP_UP,
      .STEP_ACK, .BIT_WORD, .BIT_ACK, .POWERUP_SYNC, .SEL_POS, .ALARMS, .NV_WR, .NV_RD_DATA,
      .IRQ);
   sgs_operands #(.STEP_GAP(50 * TICK)) part_u (.clk(CLK), .step_up(STEP_UP),
      .step_ack(STEP_ACK), .bit_word(BIT_WORD), .bit_ack(BIT_ACK), .group_req(GROUP_REQ),
      .group_block(GROUP_CHANGE_BLOCK));

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs

   // Indicator pattern of the highest request
   function automatic logic [5:0] top_grp(input logic [5:1] r);
      top_grp = 6'h01;
      for (int k = 1; k < 6; k++) begin
         if (r[k]) begin
            top_grp = 6'h01 << k;
         end
      end
   endfunction : top_grp

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      rd_q.push_back(e);
      @(posedge CLK);
      RD <= 1'b0;
   endtask : rd

   // Waits for every noted position to be applied
   task automatic drain();
      for (int k = 0; k < 400 && ap_q.size() > 0; k++) begin
         @(posedge CLK);
      end
      check(32'(ap_q.size()), 32'h0);
      ap_q.delete();
   endtask : drain

   task automatic report_and_stop();
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // Output watcher: takes the oldest note when an answer appears; also the hang limit
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      rd_d <= RD;
      if (rd_d && rd_q.size() > 0) begin
         check(RDATA, rd_q.pop_front());
      end
      if (NV_WR.stb === 1'b1 && ap_q.size() > 0) begin
         check(32'(NV_WR.pos), 32'(ap_q[0]));
         check(32'(SEL_POS), 32'(ap_q.pop_front()));
      end
      if (cyc == 40000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (12) @(posedge CLK);
      check(32'(SEL_POS), 32'h3);
      // Second power-up restores the stored place
      SYS_RST <= 1'b1;
      POWERUP_SYNC <= 1'b0;
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (12) @(posedge CLK);
      check(32'(SEL_POS), 32'h2);
      rd(8'h00, 32'h7);
      rd(8'h04, 32'h1388);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      wr(8'h04, 32'h5);
      wr(8'h00, 32'h5);
      rd(8'h00, 32'h5);
      // Random requests; odd passes change them under the block
      for (i = 0; i < 16; i++) begin
         req = (i == 0) ? 5'h00 : 5'(xs());
         if (i[0]) begin
            part_u.set_groups(GROUP_REQ, 1'b1);
            repeat (12) @(posedge CLK);
         end else begin
            grp = top_grp(req);
         end
         part_u.set_groups(req, i[0]);
         repeat (12) @(posedge CLK);
         check(32'(GROUP_LED), 32'(grp));
      end
      // Steps 3, 4, 5 then wrap to 1
      for (i = 0; i < 4; i++) begin
         ap_q.push_back(3'((2 + i) % 5 + 1));
         part_u.pulse(0);
         drain();
      end
      part_u.set_word(3'h7);
      repeat (20) @(posedge CLK);
      check(32'(ALARMS.range), 32'h1);
      part_u.set_word(3'h0);
      repeat (40) @(posedge CLK);
      check(32'(SEL_POS), 32'h1);
      ap_q.push_back(3'h4);
      part_u.set_word(3'h4);
      drain();
      // Interrupt masked, unmasked, cleared
      check(32'(IRQ), 32'h0);
      wr(8'h10, 32'h2);
      repeat (2) @(posedge CLK);
      check(32'(IRQ), 32'h1);
      wr(8'h0c, 32'h2);
      repeat (2) @(posedge CLK);
      check(32'(IRQ), 32'h0);
      rd(8'h0c, 32'h1);
      // Unconfirmed step is dropped with an alarm
      wr(8'h00, 32'hd);
      part_u.pulse(0);
      repeat (60) @(posedge CLK);
      check(32'(ALARMS.step), 32'h1);
      check(32'(SEL_POS), 32'h4);
      // Confirmed step; word change meanwhile is locked out
      ap_q.push_back(3'h5);
      part_u.pulse(0);
      part_u.set_word(3'h3);
      part_u.pulse(1);
      drain();
      repeat (40) @(posedge CLK);
      check(32'(SEL_POS), 32'h5);
      wr(8'h00, 32'h1d);
      ap_q.push_back(3'h2);
      part_u.set_word(3'h2);
      repeat (8) @(posedge CLK);
      part_u.pulse(2);
      drain();
      // Unconfirmed word is dropped with an alarm
      part_u.set_word(3'h3);
      repeat (60) @(posedge CLK);
      check(32'(ALARMS.bits), 32'h1);
      check(32'(SEL_POS), 32'h2);
      // Range alarm lasts 3000 ticks
      repeat (13000) @(posedge CLK);
      check(32'(ALARMS.range), 32'h0);
      // Third power-up: stored place out of range gives position 0 and an alarm
      SYS_RST <= 1'b1;
      NV_RD_DATA <= 3'h0;
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (12) @(posedge CLK);
      check(32'(SEL_POS), 32'h0);
      check(32'(ALARMS.pwr), 32'h1);
      // Write under a low clock enable is lost
      CE <= 1'b0;
      wr(8'h04, 32'h9);
      CE <= 1'b1;
      rd(8'h04, 32'h1388);
      repeat (3) @(posedge CLK);
      report_and_stop();
   end
endmodule : tb_setting_group_selector
